// file: design/rwd_crc_unit.sv
`timescale 1ns/1ps
`default_nettype none

module rwd_crc_unit #(
  parameter int MASK_BYTES = rwd_pkg::MASK_BYTES_DEF
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  byte_valid_i,
  input  wire logic [7:0]            byte_i,
  input  wire logic                  sof_i,
  input  wire logic [10:0]           pos_i,
  input  wire logic [7:0]            offset_i,
  input  wire logic [MASK_BYTES-1:0] mask_i,
  output logic      [15:0]           crc_o
);

  localparam int RW = $clog2(MASK_BYTES);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic [15:0] crc_base;
  logic [10:0] rel;
  logic        use_byte;

  // ---------------------------------------------------------------------
  // Bytewise CRC-16, most significant bit first.
  // ---------------------------------------------------------------------
  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--) begin
      if (r[15] ^ d[b]) begin
        r = {r[14:0], 1'b0} ^ rwd_pkg::CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crc16_byte

  assign rel = pos_i - {3'h0, offset_i};

  always_comb begin
    use_byte = byte_valid_i && (pos_i >= {3'h0, offset_i})
               && (rel < 11'(MASK_BYTES)) && mask_i[rel[RW-1:0]];
    crc_base = sof_i ? rwd_pkg::CRC_INIT : crc_reg;
    crc_next = crc_reg;
    if (byte_valid_i) begin
      crc_next = use_byte ? crc16_byte(crc_base, byte_i) : crc_base;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      crc_reg <= rwd_pkg::CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc_o = crc_reg;

endmodule : rwd_crc_unit

`default_nettype wire

// file: design/rwd_top.sv
// What this block does
// - Per-filter 8-bit offset, zero is first DA byte.
// - 128-bit byte mask selects bytes fed to CRC.
// - Compare computed CRC with stored 16-bit value.
// - Only enabled filters may match.
// - Wake only with global enable, listed cases.
// - Broadcast CRC hit wakes despite broadcast disable.
// - Unicast hit wakes when global unicast enabled.
// - Address type gates hits passing regular filter.
// - Pattern mode suppresses normal data reception.
// - Pattern hit sets flag and remote wakeup.
// - Pattern scan accepts own or broadcast address.
// - Multicast frames also accepted with pattern.
// - Six FF sync bytes after address fields.
// - Sixteen station address copies follow sync.
`timescale 1ns/1ps
`default_nettype none

module rwd_top #(
  parameter int NUM_FILT   = rwd_pkg::NUM_FILT_DEF,
  parameter int MASK_BYTES = rwd_pkg::MASK_BYTES_DEF
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_sof_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_err_i,
  input  wire logic        rx_filter_pass_i,
  output logic             rx_suppress_o,
  output logic             remote_wakeup_o,
  output logic             irq_o
);

  localparam int FI_W = (NUM_FILT > 1) ? $clog2(NUM_FILT) : 1;
  localparam int MW   = MASK_BYTES / 32;

  // ---------------------------------------------------------------------
  // State declarations.
  // ---------------------------------------------------------------------
  logic [31:0]           ctrl_reg,   ctrl_next;
  logic [1:0]            stat_reg,   stat_next;
  logic [1:0]            imask_reg,  imask_next;
  logic [47:0]           sta_reg,    sta_next;
  logic [NUM_FILT-1:0]   hit_reg,    hit_next;
  logic [NUM_FILT-1:0]   en_reg,     en_next;
  logic [1:0]            type_reg    [NUM_FILT];
  logic [1:0]            type_next   [NUM_FILT];
  logic [7:0]            off_reg     [NUM_FILT];
  logic [7:0]            off_next    [NUM_FILT];
  logic [15:0]           exp_reg     [NUM_FILT];
  logic [15:0]           exp_next    [NUM_FILT];
  logic [MASK_BYTES-1:0] mask_reg    [NUM_FILT];
  logic [MASK_BYTES-1:0] mask_next   [NUM_FILT];
  logic [31:0]           prdata_reg, prdata_next;
  logic                  wake_reg,   wake_next;

  logic [10:0]           idx_reg,    idx_next;
  logic [47:0]           da_reg,     da_next;
  logic                  eval_reg,   eval_next;
  logic                  pass_reg,   pass_next;

  rwd_pkg::rwd_mp_state_e mp_reg,    mp_next;
  logic [2:0]            ff_reg,     ff_next;
  logic [2:0]            bpos_reg,   bpos_next;
  logic [4:0]            rep_reg,    rep_next;

  logic [10:0]           pos_cur;
  logic [15:0]           crc_val     [NUM_FILT];
  logic [NUM_FILT-1:0]   qual;
  logic                  is_bc, is_mc, is_uc, is_own;
  logic                  wf_event, ap_event;
  logic                  rd_ok;
  logic [31:0]           rd_val;
  logic                  acc_filt;
  logic [FI_W-1:0]       acc_f;
  logic [2:0]            acc_w;
  logic                  wr_en;

  // ---------------------------------------------------------------------
  // Address decode helpers.
  // ---------------------------------------------------------------------
  function automatic logic in_filt(input logic [11:0] a);
    return (int'(a) >= int'(rwd_pkg::FILT_BASE)) &&
           (int'(a) < int'(rwd_pkg::FILT_BASE)
                      + (NUM_FILT << rwd_pkg::FILT_STRIDE_LOG));
  endfunction : in_filt

  function automatic logic [FI_W-1:0] fidx(input logic [11:0] a);
    logic [11:0] d;
    d = a - rwd_pkg::FILT_BASE;
    return d[rwd_pkg::FILT_STRIDE_LOG +: FI_W];
  endfunction : fidx

  function automatic logic [7:0] sta_byte(input logic [47:0] s,
                                          input logic [2:0]  p);
    return s[8*p +: 8];
  endfunction : sta_byte

  assign acc_filt = in_filt(paddr_i);
  assign acc_f    = fidx(paddr_i);
  assign acc_w    = paddr_i[4:2];
  assign wr_en    = psel_i && penable_i && pwrite_i && rd_ok;

  // ---------------------------------------------------------------------
  // APB read decode; reads are captured in the setup cycle.
  // ---------------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = (paddr_i[1:0] == 2'h0);
    if (acc_filt) begin
      unique case (acc_w)
        rwd_pkg::FW_CMD: begin
          rd_val[rwd_pkg::CMD_EN_BIT]        = en_reg[acc_f];
          rd_val[rwd_pkg::CMD_TYPE_LSB +: 2] = type_reg[acc_f];
        end
        rwd_pkg::FW_OFFSET: rd_val[7:0]  = off_reg[acc_f];
        rwd_pkg::FW_CRC:    rd_val[15:0] = exp_reg[acc_f];
        3'h3: rd_ok = 1'b0;
        default: begin
          if (int'(acc_w - rwd_pkg::FW_MASK0) < MW) begin
            rd_val = mask_reg[acc_f][32*(acc_w - rwd_pkg::FW_MASK0) +: 32];
          end else begin
            rd_ok = 1'b0;
          end
        end
      endcase
    end else begin
      case (paddr_i)
        rwd_pkg::CTRL_OFF:   rd_val = ctrl_reg;
        rwd_pkg::STAT_OFF:   rd_val[1:0] = stat_reg;
        rwd_pkg::IMASK_OFF:  rd_val[1:0] = imask_reg;
        rwd_pkg::STA_LO_OFF: rd_val = sta_reg[31:0];
        rwd_pkg::STA_HI_OFF: rd_val[15:0] = sta_reg[47:32];
        rwd_pkg::HIT_OFF:    rd_val[NUM_FILT-1:0] = hit_reg;
        default:             rd_ok = 1'b0;
      endcase
    end
  end

  assign pready_o  = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !rd_ok;
  assign prdata_o  = prdata_reg;

  // ---------------------------------------------------------------------
  // Frame tracking: byte position, destination address, end of frame.
  // ---------------------------------------------------------------------
  assign pos_cur = rx_sof_i ? 11'h000 : idx_reg;

  always_comb begin
    idx_next  = idx_reg;
    da_next   = da_reg;
    eval_next = rx_valid_i && rx_eof_i && !rx_err_i;
    pass_next = pass_reg;
    if (rx_valid_i) begin
      if (pos_cur != 11'h7FF) begin
        idx_next = pos_cur + 11'h001;
      end
      if (pos_cur < rwd_pkg::DA_BYTES) begin
        da_next[8*pos_cur[2:0] +: 8] = rx_data_i;
      end
      if (rx_eof_i) begin
        pass_next = rx_filter_pass_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      idx_reg  <= 11'h000;
      da_reg   <= 48'h0000_0000_0000;
      eval_reg <= 1'b0;
      pass_reg <= 1'b0;
    end else begin
      idx_reg  <= idx_next;
      da_reg   <= da_next;
      eval_reg <= eval_next;
      pass_reg <= pass_next;
    end
  end

  assign is_bc  = (da_reg == {48{1'b1}});
  assign is_mc  = da_reg[0] && !is_bc;
  assign is_uc  = !da_reg[0];
  assign is_own = (da_reg == sta_reg);

  // ---------------------------------------------------------------------
  // Pattern filters.
  // ---------------------------------------------------------------------
  for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
    rwd_crc_unit #(.MASK_BYTES(MASK_BYTES)) u_crc (
      .core_clk_i   (core_clk_i),
      .reset_i      (reset_i),
      .byte_valid_i (rx_valid_i),
      .byte_i       (rx_data_i),
      .sof_i        (rx_sof_i),
      .pos_i        (pos_cur),
      .offset_i     (off_reg[g]),
      .mask_i       (mask_reg[g]),
      .crc_o        (crc_val[g])
    );
  end

  always_comb begin
    for (int i = 0; i < NUM_FILT; i++) begin
      qual[i] = en_reg[i] && (crc_val[i] == exp_reg[i])
        && (is_bc
            || (ctrl_reg[rwd_pkg::CTRL_UNI_BIT] && is_uc)
            || (pass_reg && (type_reg[i][0]
                || (type_reg[i] == rwd_pkg::ATYPE_MULTI && is_mc)
                || (type_reg[i] == rwd_pkg::ATYPE_UNI && is_uc))));
    end
  end

  assign wf_event = eval_reg && ctrl_reg[rwd_pkg::CTRL_WFE_BIT]
                    && (|qual);
  assign ap_event = eval_reg && ctrl_reg[rwd_pkg::CTRL_APWE_BIT]
                    && (mp_reg == rwd_pkg::MP_FOUND)
                    && (is_own || is_bc || is_mc);

  // ---------------------------------------------------------------------
  // Address-pattern scan: sync run, then sixteen address copies.
  // ---------------------------------------------------------------------
  always_comb begin
    mp_next   = mp_reg;
    ff_next   = ff_reg;
    bpos_next = bpos_reg;
    rep_next  = rep_reg;
    if (rx_valid_i) begin
      if (rx_sof_i) begin
        mp_next = rwd_pkg::MP_SEARCH;
        ff_next = 3'h0;
      end else if (pos_cur >= rwd_pkg::HDR_BYTES) begin
        unique case (mp_reg)
          rwd_pkg::MP_SEARCH: begin
            if (rx_data_i == rwd_pkg::SYNC_BYTE) begin
              ff_next = ff_reg + 3'h1;
              if (ff_reg + 3'h1 == rwd_pkg::SYNC_LEN) begin
                mp_next   = rwd_pkg::MP_MATCH;
                bpos_next = 3'h0;
                rep_next  = 5'h00;
              end
            end else begin
              ff_next = 3'h0;
            end
          end
          rwd_pkg::MP_MATCH: begin
            if (rx_data_i == sta_byte(sta_reg, bpos_reg)) begin
              if (bpos_reg == rwd_pkg::ADDR_LAST_BYTE) begin
                bpos_next = 3'h0;
                rep_next  = rep_reg + 5'h01;
                if (rep_reg + 5'h01 == rwd_pkg::ADDR_REPS) begin
                  mp_next = rwd_pkg::MP_FOUND;
                end
              end else begin
                bpos_next = bpos_reg + 3'h1;
              end
            end else if (rx_data_i == rwd_pkg::SYNC_BYTE
                         && bpos_reg == 3'h0 && rep_reg == 5'h00) begin
              mp_next = rwd_pkg::MP_MATCH;
            end else begin
              mp_next = rwd_pkg::MP_SEARCH;
              ff_next = (rx_data_i == rwd_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
            end
          end
          rwd_pkg::MP_FOUND: mp_next = rwd_pkg::MP_FOUND;
          default:           mp_next = rwd_pkg::MP_SEARCH;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mp_reg   <= rwd_pkg::MP_SEARCH;
      ff_reg   <= 3'h0;
      bpos_reg <= 3'h0;
      rep_reg  <= 5'h00;
    end else begin
      mp_reg   <= mp_next;
      ff_reg   <= ff_next;
      bpos_reg <= bpos_next;
      rep_reg  <= rep_next;
    end
  end

  // ---------------------------------------------------------------------
  // Register file, status and wake outputs.
  // ---------------------------------------------------------------------
  always_comb begin
    ctrl_next   = ctrl_reg;
    imask_next  = imask_reg;
    sta_next    = sta_reg;
    en_next     = en_reg;
    type_next   = type_reg;
    off_next    = off_reg;
    exp_next    = exp_reg;
    mask_next   = mask_reg;
    hit_next    = wf_event ? qual : hit_reg;
    prdata_next = (psel_i && !penable_i) ? rd_val : prdata_reg;
    wake_next   = wf_event || ap_event;
    stat_next   = stat_reg;
    if (wr_en && acc_filt) begin
      unique case (acc_w)
        rwd_pkg::FW_CMD: begin
          en_next[acc_f]   = pwdata_i[rwd_pkg::CMD_EN_BIT];
          type_next[acc_f] = pwdata_i[rwd_pkg::CMD_TYPE_LSB +: 2];
        end
        rwd_pkg::FW_OFFSET: off_next[acc_f] = pwdata_i[7:0];
        rwd_pkg::FW_CRC:    exp_next[acc_f] = pwdata_i[15:0];
        3'h3: ;
        default: begin
          mask_next[acc_f][32*(acc_w - rwd_pkg::FW_MASK0) +: 32] = pwdata_i;
        end
      endcase
    end else if (wr_en) begin
      case (paddr_i)
        rwd_pkg::CTRL_OFF:   ctrl_next = pwdata_i & rwd_pkg::CTRL_WMASK;
        rwd_pkg::STAT_OFF:   stat_next = stat_reg & ~pwdata_i[1:0];
        rwd_pkg::IMASK_OFF:  imask_next = pwdata_i[1:0];
        rwd_pkg::STA_LO_OFF: sta_next[31:0] = pwdata_i;
        rwd_pkg::STA_HI_OFF: sta_next[47:32] = pwdata_i[15:0];
        default: ;
      endcase
    end
    // A hardware event in the clearing cycle wins over the clear.
    stat_next[rwd_pkg::STAT_WF_BIT] = stat_next[rwd_pkg::STAT_WF_BIT]
                                      | wf_event;
    stat_next[rwd_pkg::STAT_AP_BIT] = stat_next[rwd_pkg::STAT_AP_BIT]
                                      | ap_event;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_reg   <= rwd_pkg::CTRL_RST;
      stat_reg   <= rwd_pkg::STAT_RST;
      imask_reg  <= rwd_pkg::IMASK_RST;
      sta_reg    <= rwd_pkg::STA_RST;
      hit_reg    <= '0;
      en_reg     <= '0;
      prdata_reg <= 32'h0000_0000;
      wake_reg   <= 1'b0;
      for (int i = 0; i < NUM_FILT; i++) begin
        type_reg[i] <= 2'h0;
        off_reg[i]  <= 8'h00;
        exp_reg[i]  <= 16'h0000;
        mask_reg[i] <= '0;
      end
    end else begin
      ctrl_reg   <= ctrl_next;
      stat_reg   <= stat_next;
      imask_reg  <= imask_next;
      sta_reg    <= sta_next;
      hit_reg    <= hit_next;
      en_reg     <= en_next;
      prdata_reg <= prdata_next;
      wake_reg   <= wake_next;
      type_reg   <= type_next;
      off_reg    <= off_next;
      exp_reg    <= exp_next;
      mask_reg   <= mask_next;
    end
  end

  assign rx_suppress_o   = ctrl_reg[rwd_pkg::CTRL_APWE_BIT];
  assign remote_wakeup_o = wake_reg;
  assign irq_o           = |(stat_reg & imask_reg);

endmodule : rwd_top

`default_nettype wire

// file: dv/rwd_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module rwd_assertions #(
  parameter int NUM_FILT   = 8,
  parameter int MASK_BYTES = 128
) (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rx_valid_i,
  input wire logic        rx_eof_i,
  input wire logic        rx_err_i,
  input wire logic        rx_suppress_o,
  input wire logic        remote_wakeup_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic acc;
  logic ctl_wr;
  assign acc    = psel_i & penable_i;
  assign ctl_wr = acc & pwrite_i & (paddr_i == rwd_pkg::CTRL_OFF);

  ready_now_a: assert property (pready_o == acc)
    else $error("pready does not match the access phase");
  bad_addr_a: assert property (acc && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("misaligned access not refused");
  wake_pulse_a: assert property (remote_wakeup_o |=> !remote_wakeup_o)
    else $error("wakeup pulse longer than one cycle");
  wake_cause_a: assert property (
    remote_wakeup_o |-> $past(rx_valid_i & rx_eof_i, 2))
    else $error("wakeup not two cycles after a frame end");
  err_frame_a: assert property (
    rx_valid_i && rx_eof_i && rx_err_i |-> ##2 !remote_wakeup_o)
    else $error("bad frame raised a wakeup");
  mode_set_a: assert property (
    ctl_wr |=> rx_suppress_o == $past(pwdata_i[1]))
    else $error("suppress does not follow the control write");
  mode_hold_a: assert property (!ctl_wr |=> $stable(rx_suppress_o))
    else $error("suppress changed without a control write");
  mode_read_a: assert property (
    acc && !pwrite_i && paddr_i == rwd_pkg::CTRL_OFF
    |-> prdata_o[1] == rx_suppress_o)
    else $error("control readback disagrees with suppress");

  cover property (remote_wakeup_o);
  cover property (rx_valid_i && rx_eof_i && rx_err_i);
  cover property (acc && pslverr_o);
endmodule : rwd_assertions

bind rwd_top rwd_assertions #(.NUM_FILT(NUM_FILT), .MASK_BYTES(MASK_BYTES))
  u_chk (.core_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
         .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_valid_i,
         .rx_eof_i, .rx_err_i, .rx_suppress_o, .remote_wakeup_o);

`default_nettype wire

// file: dv/rwd_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module rwd_rx_model (
  input  wire logic       core_clk_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_sof_o,
  output logic            rx_eof_o,
  output logic            rx_err_o,
  output logic            rx_pass_o
);
  initial begin
    rx_valid_o = 1'h0;
    rx_data_o  = 8'h5A;
    rx_sof_o   = 1'h0;
    rx_eof_o   = 1'h0;
    rx_err_o   = 1'h0;
    rx_pass_o  = 1'h0;
  end

  // Status lines carry the opposite value except on the last byte, so
  // sampling them early is caught.
  task automatic send(input logic [7:0] f [128], input int n,
                      input logic e, input logic p);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      rx_valid_o <= 1'h1;
      rx_data_o  <= f[i];
      rx_sof_o   <= (i == 0);
      rx_eof_o   <= (i == n - 1);
      rx_err_o   <= (i == n - 1) ? e : ~e;
      rx_pass_o  <= (i == n - 1) ? p : ~p;
    end
    @(posedge core_clk_i);
    rx_valid_o <= 1'h0;
    rx_sof_o   <= 1'h0;
    rx_eof_o   <= 1'h0;
    rx_data_o  <= ~rx_data_o;
  endtask : send
endmodule : rwd_rx_model

`default_nettype wire

// file: dv/tb_rx_wake_frame_detector.sv
`timescale 1ns/1ps
`default_nettype none

module tb_rx_wake_frame_detector;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] UC = 48'h02AA_BBCC_DDEE;
  localparam logic [47:0] MC = 48'h0100_5E00_0001;
  localparam logic [47:0] STA = 48'h0211_2233_4455;
  logic        core_clk_i, reset_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o, rx_suppress_o, remote_wakeup_o, irq_o;
  logic        rx_valid_i, rx_sof_i, rx_eof_i, rx_err_i, rx_pass_i;
  logic [7:0]  rx_data_i;
  logic [7:0]  fr [128];
  int          err_count = 0;
  int          checks_done = 0;
  int          wake_n = 0;

  rwd_top dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_sof_i(rx_sof_i), .rx_eof_i(rx_eof_i), .rx_err_i(rx_err_i),
    .rx_filter_pass_i(rx_pass_i), .rx_suppress_o(rx_suppress_o),
    .remote_wakeup_o(remote_wakeup_o), .irq_o(irq_o));
  rwd_rx_model rx (.core_clk_i(core_clk_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_sof_o(rx_sof_i), .rx_eof_o(rx_eof_i),
    .rx_err_o(rx_err_i), .rx_pass_o(rx_pass_i));

  initial begin
    core_clk_i = 1'h0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (remote_wakeup_o === 1'h1) wake_n++;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel_i    <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'h1);
    r = prdata_o;
    psel_i    <= 1'h0;
    penable_i <= 1'h0;
    @(posedge core_clk_i);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'h0, a, 32'h0, r);
    chk(r, e);
  endtask : rd

  function automatic logic [15:0] crc16(input int n);
    logic [15:0] c;
    c = rwd_pkg::CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {fr[i], 8'h00};
      for (int b = 0; b < 8; b++)
        c = c[15] ? {c[14:0], 1'h0} ^ rwd_pkg::CRC_POLY : {c[14:0], 1'h0};
    end
    return c;
  endfunction : crc16

  task automatic frame(input int n, input logic e, input logic p,
                       input logic x);
    int w0;
    w0 = wake_n;
    rx.send(fr, n, e, p);
    repeat (4) @(posedge core_clk_i);
    chk(32'(wake_n - w0), {31'h0, x});
  endtask : frame

  task automatic pat(input logic [47:0] da, input int reps, input logic x);
    for (int i = 0; i < 12; i++) fr[i] = (i < 6) ? da[47-8*i -: 8] : 8'h0A;
    for (int i = 12; i < 18; i++) fr[i] = rwd_pkg::SYNC_BYTE;
    for (int i = 0; i < 6 * reps; i++) fr[18+i] = STA[47-8*(i%6) -: 8];
    fr[18+6*reps] = 8'h00;
    frame(19 + 6 * reps, 1'h0, 1'h0, x);
    rd(rwd_pkg::STAT_OFF, {30'h0, x, 1'h0});
    chk({31'h0, irq_o}, {31'h0, x});
    wr(rwd_pkg::STAT_OFF, 32'h2);
  endtask : pat

  task automatic fcase(input logic [47:0] da, input logic [3:0] cmd,
                       input logic [31:0] ctl, input logic e, input logic p,
                       input logic [15:0] cx, input logic x);
    for (int i = 0; i < 14; i++) fr[i] = (i < 6) ? da[47-8*i -: 8] : 8'(i);
    wr(rwd_pkg::CTRL_OFF, ctl);
    wr(12'h040, {28'h0, cmd});
    wr(12'h048, {16'h0, crc16(6) ^ cx});
    frame(14, e, p, x);
    rd(rwd_pkg::STAT_OFF, {31'h0, x});
    chk({31'h0, irq_o}, {31'h0, x});
    wr(rwd_pkg::STAT_OFF, 32'h1);
  endtask : fcase

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {psel_i, penable_i, pwrite_i} = 3'h0;
    paddr_i  = 12'h000;
    pwdata_i = 32'h0;
    reset_i  = 1'h1;
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'h0;
    rd(rwd_pkg::CTRL_OFF, 32'h0);
    rd(rwd_pkg::STAT_OFF, 32'h0);
    rd(rwd_pkg::IMASK_OFF, 32'h0);
    rd(12'h04C, 32'h0);
    rd(12'h002, 32'h0);
    wr(rwd_pkg::CTRL_OFF, 32'hFFFF_FFFF);
    rd(rwd_pkg::CTRL_OFF, 32'h0000_0203);
    wr(rwd_pkg::STA_LO_OFF, 32'h3322_1102);
    wr(rwd_pkg::STA_HI_OFF, 32'h0000_5544);
    wr(rwd_pkg::IMASK_OFF, 32'h2);
    wr(rwd_pkg::CTRL_OFF, 32'h2);
    chk({31'h0, rx_suppress_o}, 32'h1);
    pat(STA, 15, 1'h0);
    pat(STA, 16, 1'h1);
    pat(BC, 16, 1'h1);
    pat(UC, 16, 1'h0);
    pat(MC, 16, 1'h1);
    chk({31'h0, irq_o}, 32'h0);
    wr(rwd_pkg::CTRL_OFF, 32'h0);
    chk({31'h0, rx_suppress_o}, 32'h0);
    wr(rwd_pkg::IMASK_OFF, 32'h1);
    wr(12'h044, 32'h0);
    wr(12'h050, 32'h3F);
    fcase(BC, 4'h1, 32'h1, 1'h0, 1'h0, 16'h0, 1'h1);
    fcase(UC, 4'h1, 32'h1, 1'h0, 1'h1, 16'h0, 1'h1);
    fcase(UC, 4'h9, 32'h1, 1'h0, 1'h1, 16'h0, 1'h0);
    fcase(MC, 4'h9, 32'h1, 1'h0, 1'h1, 16'h0, 1'h1);
    fcase(MC, 4'h9, 32'h1, 1'h0, 1'h0, 16'h0, 1'h0);
    fcase(UC, 4'h9, 32'h201, 1'h0, 1'h0, 16'h0, 1'h1);
    fcase(MC, 4'h5, 32'h1, 1'h0, 1'h1, 16'h0, 1'h1);
    fcase(UC, 4'h0, 32'h201, 1'h0, 1'h1, 16'h0, 1'h0);
    fcase(BC, 4'h1, 32'h0, 1'h0, 1'h0, 16'h0, 1'h0);
    fcase(BC, 4'h1, 32'h1, 1'h1, 1'h0, 16'h0, 1'h0);
    fcase(UC, 4'hD, 32'h1, 1'h0, 1'h1, 16'h1, 1'h0);
    fcase(MC, 4'h1, 32'h201, 1'h0, 1'h0, 16'h0, 1'h0);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    stop_test();
  end
endmodule : tb_rx_wake_frame_detector

`default_nettype wire

// file: include/rwd_pkg.sv
package rwd_pkg;

  // ---------------------------------------------------------------------
  // Register map, byte addresses on the APB.
  // ---------------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] CTRL_OFF        = 12'h000;
  localparam logic [11:0] STAT_OFF        = 12'h004;
  localparam logic [11:0] IMASK_OFF       = 12'h008;
  localparam logic [11:0] STA_LO_OFF      = 12'h00C;
  localparam logic [11:0] STA_HI_OFF      = 12'h010;
  localparam logic [11:0] HIT_OFF         = 12'h014;
  localparam logic [11:0] FILT_BASE       = 12'h040;
  localparam int          FILT_STRIDE_LOG = 5;

  // Word index inside one filter's block of eight words.
  localparam logic [2:0]  FW_CMD          = 3'h0;
  localparam logic [2:0]  FW_OFFSET       = 3'h1;
  localparam logic [2:0]  FW_CRC          = 3'h2;
  localparam logic [2:0]  FW_MASK0        = 3'h4;

  // ---------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------
  localparam int          CTRL_WFE_BIT    = 0;
  localparam int          CTRL_APWE_BIT   = 1;
  localparam int          CTRL_UNI_BIT    = 9;
  localparam int          STAT_WF_BIT     = 0;
  localparam int          STAT_AP_BIT     = 1;
  localparam int          CMD_EN_BIT      = 0;
  localparam int          CMD_TYPE_LSB    = 2;

  // ---------------------------------------------------------------------
  // Reset values and write masks.
  // ---------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK      = 32'h0000_0203;
  localparam logic [1:0]  STAT_RST        = 2'h0;
  localparam logic [1:0]  IMASK_RST       = 2'h0;
  localparam logic [47:0] STA_RST         = 48'h0000_0000_0000;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'h8005;

  // ---------------------------------------------------------------------
  // Frame constants.
  // ---------------------------------------------------------------------
  localparam int          NUM_FILT_DEF    = 8;
  localparam int          MASK_BYTES_DEF  = 128;
  localparam logic [7:0]  SYNC_BYTE       = 8'hFF;
  localparam logic [2:0]  SYNC_LEN        = 3'h6;
  localparam logic [4:0]  ADDR_REPS       = 5'h10;
  localparam logic [2:0]  ADDR_LAST_BYTE  = 3'h5;
  localparam logic [10:0] HDR_BYTES       = 11'h00C;
  localparam logic [10:0] DA_BYTES        = 11'h006;
  localparam logic [1:0]  ATYPE_UNI       = 2'h0;
  localparam logic [1:0]  ATYPE_MULTI     = 2'h2;

  typedef enum logic [2:0] {
    MP_SEARCH = 3'b001,
    MP_MATCH  = 3'b010,
    MP_FOUND  = 3'b100
  } rwd_mp_state_e;

endpackage : rwd_pkg
